// ===== periph_regs_model.sv
// peripheral register bank behind the core's peripheral bus
`timescale 1ns/1ps
`default_nettype none
module periph_regs_model (
    input  wire logic        i_ref_clk,
    input  wire logic [6:0]  i_periph_addr,
    input  wire logic [15:0] i_periph_wdata,
    input  wire logic        i_periph_we,
    output var  logic [15:0] o_periph_rdata
);
    logic [15:0] regs_q [0:127];
    wire         narrow = i_periph_addr < 7'h40;
    initial for (int k = 0; k < 128; k++) regs_q[k] = 16'h3C00 ^ {k[7:0], k[7:0]};
    // narrow registers float their upper lanes, so show the inverted low byte rather than zero
    always_comb o_periph_rdata = narrow ? {~regs_q[i_periph_addr][7:0], regs_q[i_periph_addr][7:0]}
                                        : regs_q[i_periph_addr];
    always @(posedge i_ref_clk) if (i_periph_we) regs_q[i_periph_addr] <= narrow ?
        {8'h00, i_periph_wdata[7:0]} : i_periph_wdata;
endmodule // periph_regs_model
`default_nettype wire

// ===== periph_width_table.v
// fixed per-peripheral access width lookup
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_defs.vh"
module periph_width_table (
    input  wire [6:0] i_periph_addr,
    output reg        o_is_8bit
);
    always @* begin
        // serial shift register and any peripheral below 40h are byte wide
        o_is_8bit = (i_periph_addr == `SERIAL_SHIFT_ADDR) || (i_periph_addr < 7'h40);
    end
endmodule // periph_width_table
`default_nettype wire

// ===== xfer_exec.v
// executor for stack pop, register file peek/poke, peripheral get/put and direct branch
// Summary of operation
// - pop loads the table address register from the selected stack entry, then bumps the index up.
// - register file read copies the addressed cell into the window register.
// - register file write (prefix 00111, sub-code 0010) copies the window register into the cell.
// - register file addresses 40h-7fh reach data memory of the current bank, 74h-7fh system regs.
// - the status word sits at 7fh and can be read into the window register.
// - the call stack index is visible at register file address 01h.
// - peripheral read loads the transfer buffer from the addressed peripheral.
// - the transfer buffer is a separate register, not mapped onto bank 0 data memory 0ch-0fh.
// - the transfer buffer is 16 bits; the moved width depends on the peripheral.
// - an 8-bit peripheral read fills the low two nibbles and keeps the upper two.
// - peripheral write (prefix 00111, sub-code 1010) sends the buffer to the peripheral.
// - an 8-bit peripheral write sends only the low two nibbles.
// - the serial shift register is an 8-bit peripheral.
// - direct branch (opcode 01100 plus 11-bit target) loads the instruction pointer.
// - upper six table address bits read zero, only ten bits are held.
// - push decrements the index first, then stores the table address register.
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_defs.vh"
module xfer_exec (
    input  wire        i_ref_clk,
    input  wire        i_rst,
    input  wire        i_instr_valid,
    input  wire [15:0] i_instr,
    input  wire [2:0]  i_bank,
    input  wire [3:0]  i_window_reg,
    input  wire [3:0]  i_mem_rdata,
    input  wire [3:0]  i_rf_rdata,
    input  wire [15:0] i_periph_rdata,
    output reg  [3:0]  o_window_wdata,
    output reg         o_window_we,
    output reg  [10:0] o_instr_pointer,
    output reg         o_jump,
    output reg  [15:0] o_table_address_reg,
    output reg  [2:0]  o_call_stack_index,
    output reg  [15:0] o_transfer_buffer,
    output reg  [6:0]  o_rf_addr,
    output reg  [3:0]  o_rf_wdata,
    output reg         o_rf_we,
    output reg  [10:0] o_mem_addr,
    output reg  [3:0]  o_mem_wdata,
    output reg         o_mem_we,
    output reg  [6:0]  o_periph_addr,
    output reg  [15:0] o_periph_wdata,
    output reg         o_periph_we,
    output reg         o_periph_byte
);
    reg  [9:0]  return_stack_entry [0:`STACK_DEPTH-1];
    reg  [9:0]  table_address_reg_q;
    reg  [2:0]  call_stack_index_q;
    reg  [15:0] transfer_buffer_q;
    reg         peek_pend_q;
    reg         get_pend_q;
    reg         pend_mem_q;
    reg         pend_csi_q;
    reg         pend_byte_q;
    wire [4:0]  opcode          = i_instr[15:11];
    wire [2:0]  regfile_row_field = i_instr[10:8];
    wire [3:0]  sub_code        = i_instr[7:4];
    wire [6:0]  rf_addr         = {regfile_row_field, i_instr[3:0]};
    wire        is_sys          = i_instr_valid && (opcode == `OP_PREFIX_SYS);
    wire        do_pop          = is_sys && (sub_code == `SUB_POP_AR);
    wire        do_push         = is_sys && (sub_code == `SUB_PUSH_AR);
    wire        do_peek         = is_sys && (sub_code == `SUB_PEEK);
    wire        do_poke         = is_sys && (sub_code == `SUB_POKE);
    wire        do_get          = is_sys && (sub_code == `SUB_GET);
    wire        do_put          = is_sys && (sub_code == `SUB_PUT);
    wire        direct_jump_op  = i_instr_valid && (opcode == `OP_DIRECT_JUMP);
    wire        rf_is_mem       = (rf_addr >= `RF_MEM_BASE);
    wire        rf_is_csi       = (rf_addr == `RF_CSI_ADDR);
    wire        periph_is_8bit;
    wire [2:0]  csi_dec         = call_stack_index_q - 3'd1;
    integer     k;

    periph_width_table u_width (
        .i_periph_addr (rf_addr),
        .o_is_8bit     (periph_is_8bit)
    );

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            table_address_reg_q <= 10'h000;
            call_stack_index_q  <= `CSI_RESET;
            transfer_buffer_q   <= 16'h0000;
            peek_pend_q         <= 1'b0;
            get_pend_q          <= 1'b0;
            pend_mem_q          <= 1'b0;
            pend_csi_q          <= 1'b0;
            pend_byte_q         <= 1'b0;
            o_window_wdata      <= 4'h0;
            o_window_we         <= 1'b0;
            o_instr_pointer     <= 11'h000;
            o_jump              <= 1'b0;
            o_rf_addr           <= 7'h00;
            o_rf_wdata          <= 4'h0;
            o_rf_we             <= 1'b0;
            o_mem_addr          <= 11'h000;
            o_mem_wdata         <= 4'h0;
            o_mem_we            <= 1'b0;
            o_periph_addr       <= 7'h00;
            o_periph_wdata      <= 16'h0000;
            o_periph_we         <= 1'b0;
            o_periph_byte       <= 1'b0;
            for (k = 0; k < `STACK_DEPTH; k = k + 1) begin
                return_stack_entry[k] <= 10'h000;
            end
        end else begin
            o_window_we <= 1'b0;
            o_jump      <= 1'b0;
            o_rf_we     <= 1'b0;
            o_mem_we    <= 1'b0;
            o_periph_we <= 1'b0;
            peek_pend_q <= 1'b0;
            get_pend_q  <= 1'b0;
            if (do_pop) begin
                table_address_reg_q <= return_stack_entry[call_stack_index_q];
                call_stack_index_q  <= call_stack_index_q + 3'd1;
            end
            if (do_push) begin
                call_stack_index_q           <= csi_dec;
                return_stack_entry[csi_dec]  <= table_address_reg_q;
            end
            if (direct_jump_op) begin
                o_instr_pointer <= i_instr[10:0];
                o_jump          <= 1'b1;
            end
            // reads take one cycle: address out now, data captured next cycle
            if (do_peek || do_poke) begin
                o_rf_addr   <= rf_addr;
                o_mem_addr  <= {i_bank, 1'b0, rf_addr};
                pend_mem_q  <= rf_is_mem;
                pend_csi_q  <= rf_is_csi;
            end
            if (do_peek) begin
                peek_pend_q <= 1'b1;
            end
            if (do_poke) begin
                o_rf_wdata  <= i_window_reg;
                o_mem_wdata <= i_window_reg;
                o_rf_we     <= !rf_is_mem && !rf_is_csi;
                o_mem_we    <= rf_is_mem;
                if (rf_is_csi) begin
                    call_stack_index_q <= i_window_reg[2:0];
                end
            end
            if (peek_pend_q) begin
                o_window_we <= 1'b1;
                if (pend_csi_q) begin
                    o_window_wdata <= {1'b0, call_stack_index_q};
                end else if (pend_mem_q) begin
                    o_window_wdata <= i_mem_rdata;
                end else begin
                    o_window_wdata <= i_rf_rdata;
                end
            end
            if (do_get || do_put) begin
                o_periph_addr <= rf_addr;
                o_periph_byte <= periph_is_8bit;
                pend_byte_q   <= periph_is_8bit;
            end
            if (do_get) begin
                get_pend_q <= 1'b1;
            end
            if (do_put) begin
                o_periph_we    <= 1'b1;
                // upper byte zeroed so a byte peripheral never sees stale nibbles
                o_periph_wdata <= periph_is_8bit ? {8'h00, transfer_buffer_q[7:0]}
                                                 : transfer_buffer_q;
            end
            if (get_pend_q) begin
                if (pend_byte_q) begin
                    transfer_buffer_q[7:0] <= i_periph_rdata[7:0];
                end else begin
                    transfer_buffer_q <= i_periph_rdata;
                end
            end
        end
    end

    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_table_address_reg <= 16'h0000;
            o_call_stack_index  <= 3'h0;
            o_transfer_buffer   <= 16'h0000;
        end else begin
            o_table_address_reg <= {6'h00, table_address_reg_q};
            o_call_stack_index  <= call_stack_index_q;
            o_transfer_buffer   <= transfer_buffer_q;
        end
    end
endmodule // xfer_exec
`default_nettype wire

// ===== xfer_exec_assertions.sv
// port checker for the transfer executor
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_defs.vh"
module xfer_exec_assertions (
    input wire        i_ref_clk,
    input wire        i_rst,
    input wire        i_instr_valid,
    input wire [15:0] i_instr,
    input wire [2:0]  i_bank,
    input wire [3:0]  i_window_reg,
    input wire [3:0]  i_mem_rdata,
    input wire [3:0]  o_window_wdata,
    input wire        o_window_we,
    input wire [10:0] o_instr_pointer,
    input wire        o_jump,
    input wire [15:0] o_table_address_reg,
    input wire [2:0]  o_call_stack_index,
    input wire [10:0] o_mem_addr,
    input wire [3:0]  o_mem_wdata,
    input wire        o_mem_we,
    input wire [6:0]  o_periph_addr,
    input wire [15:0] o_periph_wdata,
    input wire        o_periph_we,
    input wire        o_periph_byte
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire       sys = i_instr_valid && i_instr[15:11] == `OP_PREFIX_SYS;
    wire [6:0] fa  = {i_instr[10:8], i_instr[3:0]};
    jump_load_a: assert property (i_instr_valid && i_instr[15:11] == `OP_DIRECT_JUMP
        |=> o_jump && o_instr_pointer == $past(i_instr[10:0])) else $error("branch not taken");
    poke_mem_a: assert property (sys && i_instr[7:4] == `SUB_POKE && fa >= 7'h40
        |=> o_mem_we && o_mem_wdata == $past(i_window_reg)
        && o_mem_addr == {$past(i_bank), 1'b0, $past(fa)}) else $error("poke missed memory");
    peek_mem_a: assert property (sys && i_instr[7:4] == `SUB_PEEK && fa >= 7'h40
        |=> ##1 o_window_we && o_window_wdata == $past(i_mem_rdata)) else $error("peek wrong");
    put_strobe_a: assert property (sys && i_instr[7:4] == `SUB_PUT
        |=> o_periph_we && o_periph_addr == $past(fa)) else $error("put not issued");
    put_byte_a: assert property (o_periph_we && o_periph_byte
        |-> o_periph_wdata[15:8] == 8'h00) else $error("byte put drove upper lanes");
    width_sel_a: assert property (o_periph_we
        |-> o_periph_byte == (o_periph_addr < 7'h40)) else $error("width table wrong");
    ta_upper_a: assert property (o_table_address_reg[15:10] == 6'h00)
        else $error("table address upper bits set");
    pop_index_a: assert property (sys && i_instr[7:4] == `SUB_POP_AR && $past(!i_instr_valid)
        |-> ##2 o_call_stack_index == $past(o_call_stack_index, 2) + 3'h1) else $error("pop index");
endmodule // xfer_exec_assertions
bind xfer_exec xfer_exec_assertions xfer_exec_assertions_inst (.*);
`default_nettype wire

// ===== xfer_exec_bench.sv
// self-checking bench for the transfer executor
`timescale 1ns/1ps
`default_nettype none
`include "xfer_exec_defs.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module xfer_exec_bench;
    logic i_ref_clk = 0, i_rst = 1, i_instr_valid = 0;
    logic [15:0] i_instr = 0, i_periph_rdata, o_table_address_reg, o_transfer_buffer, o_periph_wdata;
    logic [2:0] i_bank = 0, o_call_stack_index;
    logic [3:0] i_window_reg = 0, i_mem_rdata = 0, i_rf_rdata = 0, o_window_wdata, o_rf_wdata;
    logic [3:0] o_mem_wdata;
    logic [10:0] o_instr_pointer, o_mem_addr;
    logic [6:0] o_rf_addr, o_periph_addr;
    logic o_window_we, o_jump, o_rf_we, o_mem_we, o_periph_we, o_periph_byte;
    int n_errors = 0, tests_run = 0;
    always #2 i_ref_clk = ~i_ref_clk;
    xfer_exec xfer_exec_inst (.*);
    periph_regs_model periph_regs_model_inst (.i_ref_clk(i_ref_clk), .i_periph_addr(o_periph_addr),
        .i_periph_wdata(o_periph_wdata), .i_periph_we(o_periph_we), .o_periph_rdata(i_periph_rdata));
    function automatic [15:0] sys(input [6:0] a, input [3:0] s);
        sys = {`OP_PREFIX_SYS, a[6:4], s, a[3:0]};
    endfunction
    function automatic [15:0] pat(input [7:0] a);
        pat = 16'h3C00 ^ {a, a};
    endfunction
    task automatic op(input [15:0] w);
        @(negedge i_ref_clk) begin i_instr_valid = 1; i_instr = w; end
        @(negedge i_ref_clk) i_instr_valid = 0;
    endtask
    task automatic final_report;
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_regfile;
        op(sys(`RF_CSI_ADDR, `SUB_PEEK)); @(negedge i_ref_clk);
        `CHK("csi peek", 4'h7, o_window_wdata)
        i_window_reg = 4'hB; i_bank = 3'h5; op(sys(7'h45, `SUB_POKE));
        `CHK("poke we", 1'b1, o_mem_we)
        `CHK("poke addr", {3'h5, 1'b0, 7'h45}, o_mem_addr)
        `CHK("poke data", 4'hB, o_mem_wdata)
        i_mem_rdata = 4'h6; op(sys(`RF_PSW_ADDR, `SUB_PEEK)); @(negedge i_ref_clk);
        `CHK("psw peek", 4'h6, o_window_wdata)
    endtask
    task automatic t_stack;
        op(sys(7'h00, `SUB_PUSH_AR)); repeat (2) @(negedge i_ref_clk);
        `CHK("push csi", 3'h6, o_call_stack_index)
        op(sys(7'h00, `SUB_POP_AR)); repeat (2) @(negedge i_ref_clk);
        `CHK("pop csi", 3'h7, o_call_stack_index)
        `CHK("pop ta", 16'h0000, o_table_address_reg)
    endtask
    task automatic t_periph;
        op(sys(7'h50, `SUB_GET)); repeat (3) @(negedge i_ref_clk);
        `CHK("get wide", pat(8'h50), o_transfer_buffer)
        op(sys(`SERIAL_SHIFT_ADDR, `SUB_GET)); repeat (3) @(negedge i_ref_clk);
        `CHK("get byte", (pat(8'h50) & 16'hFF00) | (pat(8'h02) & 16'h00FF), o_transfer_buffer)
        op(sys(`SERIAL_SHIFT_ADDR, `SUB_PUT));
        `CHK("put byte", {1'b1, pat(8'h02) & 16'h00FF}, {o_periph_byte, o_periph_wdata})
        op(sys(7'h61, `SUB_PUT));
        `CHK("put wide", {1'b0, (pat(8'h50) & 16'hFF00) | (pat(8'h02) & 16'h00FF)},
             {o_periph_byte, o_periph_wdata})
    endtask
    task automatic t_jump;
        op({`OP_DIRECT_JUMP, 11'h5A3});
        `CHK("jump", {1'b1, 11'h5A3}, {o_jump, o_instr_pointer})
    endtask
    initial begin
        repeat (4) @(negedge i_ref_clk);
        i_rst = 0;
        repeat (2) @(negedge i_ref_clk);
        `CHK("reset csi", 3'h7, o_call_stack_index)
        t_regfile;
        t_stack;
        t_periph;
        t_jump;
        final_report;
    end
    // whole run is well under a few hundred cycles
    initial begin #20000 n_errors++; final_report; end
endmodule // xfer_exec_bench
`default_nettype wire

// ===== xfer_exec_defs.vh
// constants for the register file / peripheral transfer executor
`ifndef XFER_EXEC_DEFS_VH
`define XFER_EXEC_DEFS_VH
`define OP_PREFIX_SYS      5'h07
`define OP_DIRECT_JUMP     5'h0C
`define SUB_POP_AR         4'hC
`define SUB_PUSH_AR        4'hD
`define SUB_PEEK           4'h3
`define SUB_POKE           4'h2
`define SUB_GET            4'hB
`define SUB_PUT            4'hA
`define RF_CSI_ADDR        7'h01
`define RF_MEM_BASE        7'h40
`define RF_PSW_ADDR        7'h7F
`define TB_BANK0_NIB0      7'h0C
`define STACK_DEPTH        8
`define CSI_RESET          3'h7
`define TA_USED_BITS       10
`define PERIPH_COUNT       128
`define SERIAL_SHIFT_ADDR  7'h02
`endif
